// ==== lcc_pkg.sv ====
package lcc_pkg;
    // register offsets are not multiples of four: kept as indices, byte address = 4 * index
    localparam logic [15:0] LCC_IDX_PORT_DUTY = 16'hffc0;
    localparam logic [15:0] LCC_IDX_DISPLAY = 16'hffc1;
    localparam logic [15:0] LCC_IDX_WAVE_SUPPLY = 16'hffc2;
    localparam logic [7:0] LCC_RST_PORT_DUTY = 8'h00;
    localparam logic [7:0] LCC_RST_DISPLAY = 8'h80;
    localparam logic [7:0] LCC_RST_WAVE_SUPPLY = 8'h60;
    // port_duty_control fields
    localparam int LCC_DUTY_HI = 7;
    localparam int LCC_DUTY_LO = 6;
    localparam int LCC_COMMON_DOUBLING = 5;
    localparam int LCC_EXPANSION_SELECT = 4;
    // display_control fields
    localparam int LCC_DRIVE_SUPPLY_SWITCH = 6;
    localparam int LCC_CONTROLLER_RUN = 5;
    localparam int LCC_SHOW_RAM_DATA = 4;
    // waveform_supply_control fields
    localparam int LCC_WAVEFORM_TYPE = 7;
    localparam int LCC_SUPPLY_SOURCE = 4;
    localparam int LCC_SEG_PINS = 32;
    localparam int LCC_COM_PINS = 4;
    typedef enum logic [1:0] {
        LCC_DUTY_STATIC,
        LCC_DUTY_HALF,
        LCC_DUTY_THIRD,
        LCC_DUTY_QUARTER
    } lcc_duty_e;
    // pulse duty encoding: numerator over denominator
    localparam logic [5:0] LCC_PULSE_DEN_EIGHTHS = 6'h08;
    localparam logic [5:0] LCC_PULSE_DEN_16 = 6'h10;
    localparam logic [5:0] LCC_PULSE_DEN_32 = 6'h20;
endpackage

// ==== lcc_control_regs.sv ====
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module lcc_control_regs
    import lcc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [17:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_standby,
    input wire logic i_latch_clock_out,
    input wire logic i_shift_clock_out,
    input wire logic i_serial_segment_data,
    input wire logic i_alternation,
    output logic [1:0] o_duty,
    output logic [3:0] o_com_enable,
    output logic [3:0] o_com_source_1,
    output logic [3:0] o_com_source_2,
    output logic [3:0] o_com_source_3,
    output logic [3:0] o_com_source_4,
    output logic [31:0] o_seg_driver_en,
    output logic o_expansion_active,
    output logic [3:0] o_expansion_pins,
    output logic o_drive_supply_on,
    output logic o_controller_active,
    output logic o_show_ram_data,
    output logic o_clock_from_system,
    output logic [7:0] o_frame_clock_div,
    output logic o_waveform_b,
    output logic o_regulator_run,
    output logic [5:0] o_pulse_num,
    output logic [5:0] o_pulse_den
);
    logic [7:0] port_duty_control;
    logic [7:0] display_control;
    logic [7:0] waveform_supply_control;

    wire [15:0] reg_index = i_wb_adr[17:2];
    wire bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire hit_pd = reg_index == LCC_IDX_PORT_DUTY;
    wire hit_dc = reg_index == LCC_IDX_DISPLAY;
    wire hit_ws = reg_index == LCC_IDX_WAVE_SUPPLY;
    wire wr_lane0 = bus_req && i_wb_we && i_wb_sel[0];
    wire [7:0] rd_byte = hit_pd ? port_duty_control : hit_dc ? display_control :
        hit_ws ? waveform_supply_control : 8'h00;

    // bus: one-cycle-later ack, unmapped reads return zero, writes there are dropped
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= bus_req;
            o_wb_dat <= (bus_req && !i_wb_we) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // registers keep contents while the controller is halted
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            port_duty_control <= LCC_RST_PORT_DUTY;
            display_control <= LCC_RST_DISPLAY;
            waveform_supply_control <= LCC_RST_WAVE_SUPPLY;
        end else begin
            if (wr_lane0 && hit_pd) begin
                port_duty_control <= i_wb_dat[7:0];
            end
            if (wr_lane0 && hit_dc) begin
                display_control <= i_wb_dat[7:0];
            end
            if (wr_lane0 && hit_ws) begin
                waveform_supply_control <= i_wb_dat[7:0];
            end
        end
    end

    wire [1:0] duty_sel = {port_duty_control[LCC_DUTY_HI], port_duty_control[LCC_DUTY_LO]};
    wire common_doubling = port_duty_control[LCC_COMMON_DOUBLING];
    wire expansion_select = port_duty_control[LCC_EXPANSION_SELECT];
    wire [3:0] segment_pin_select = port_duty_control[3:0];
    wire drive_supply_switch = display_control[LCC_DRIVE_SUPPLY_SWITCH];
    wire controller_run = display_control[LCC_CONTROLLER_RUN];
    wire show_ram_data = display_control[LCC_SHOW_RAM_DATA];
    wire [3:0] frame_clock_select = display_control[3:0];
    wire waveform_type = waveform_supply_control[LCC_WAVEFORM_TYPE];
    wire supply_source = waveform_supply_control[LCC_SUPPLY_SOURCE];
    wire [3:0] pulse_duty_select = waveform_supply_control[3:0];

    // number of common pins in use for the duty: 1..4
    wire [2:0] coms_used = {1'b0, duty_sel} + 3'd1;

    // per common pin, while the controller runs: enabled if used, or if unused and doubling is on; the source
    // is a one-hot mask of which used common waveform it repeats (its own, or its index modulo used), or zero if unused without doubling
    logic [3:0] next_com_en;
    logic [3:0] next_com_src [LCC_COM_PINS];
    genvar gc;
    generate
        for (gc = 0; gc < LCC_COM_PINS; gc++) begin : g_com
            wire used = 3'(gc) < coms_used;
            wire [2:0] mod_idx = 3'(gc) % coms_used;
            assign next_com_en[gc] = controller_run && (used || common_doubling);
            assign next_com_src[gc] = used ? 4'(1 << gc) : (common_doubling ? 4'(1 << mod_idx) : 4'h0);
        end
    endgenerate

    // segment drivers enabled from the top pin downward, in groups of eight
    logic [31:0] next_seg_en;
    always_comb begin
        next_seg_en = 32'h0000_0000;
        if (!expansion_select) begin
            if (segment_pin_select[3]) begin
                next_seg_en = 32'hffff_ffff;
            end else begin
                unique case (segment_pin_select[2:1])
                    2'b00: next_seg_en = 32'h0000_0000;
                    2'b01: next_seg_en = 32'hff00_0000;
                    2'b10: next_seg_en = 32'hffff_0000;
                    2'b11: next_seg_en = 32'hffff_ff00;
                endcase
            end
        end
        // expansion with nonzero select is not a legal setting; treated like 0000
        if (!controller_run) begin
            next_seg_en = 32'h0000_0000;
        end
    end

    wire next_exp_active = expansion_select && controller_run;
    // pin order from the highest segment: latch clock, shift clock, serial data, alternation
    wire [3:0] next_exp_pins = next_exp_active ?
        {i_latch_clock_out, i_shift_clock_out, i_serial_segment_data, i_alternation} : 4'h0;

    wire next_supply_on = drive_supply_switch && controller_run && !i_standby;

    // frame clock divider; subclock taps are 1, 2, 4
    logic [7:0] next_div;
    always_comb begin
        if (frame_clock_select[3]) begin
            next_div = 8'(16'h0002 << frame_clock_select[2:0]) ;
            if (frame_clock_select[2:0] == 3'h7) begin
                next_div = 8'h00; // 256 does not fit 8 bits, zero stands for 256
            end
        end else if (frame_clock_select[1]) begin
            next_div = 8'h04;
        end else begin
            next_div = frame_clock_select[0] ? 8'h02 : 8'h01;
        end
    end

    logic [5:0] next_pnum;
    logic [5:0] next_pden;
    always_comb begin
        next_pden = LCC_PULSE_DEN_EIGHTHS;
        next_pnum = 6'(pulse_duty_select[2:0]); // n/8
        if (pulse_duty_select[3]) begin
            next_pnum = 6'h01;
            next_pden = pulse_duty_select[2] ? LCC_PULSE_DEN_32 : LCC_PULSE_DEN_16;
        end else if (pulse_duty_select[2:0] == 3'h0) begin
            next_pnum = LCC_PULSE_DEN_EIGHTHS; // full duty
        end else if (pulse_duty_select[2:0] == 3'h7) begin
            next_pnum = 6'h00;
        end
    end

    // all outputs registered
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_duty <= 2'h0;
            o_com_enable <= 4'h0;
            o_com_source_1 <= 4'h0;
            o_com_source_2 <= 4'h0;
            o_com_source_3 <= 4'h0;
            o_com_source_4 <= 4'h0;
            o_seg_driver_en <= 32'h0000_0000;
            o_expansion_active <= 1'b0;
            o_expansion_pins <= 4'h0;
            o_drive_supply_on <= 1'b0;
            o_controller_active <= 1'b0;
            o_show_ram_data <= 1'b0;
            o_clock_from_system <= 1'b0;
            o_frame_clock_div <= 8'h01;
            o_waveform_b <= 1'b0;
            o_regulator_run <= 1'b0;
            o_pulse_num <= 6'h00;
            o_pulse_den <= LCC_PULSE_DEN_EIGHTHS;
        end else begin
            o_duty <= duty_sel;
            o_com_enable <= next_com_en;
            o_com_source_1 <= next_com_src[0];
            o_com_source_2 <= next_com_src[1];
            o_com_source_3 <= next_com_src[2];
            o_com_source_4 <= next_com_src[3];
            o_seg_driver_en <= next_seg_en;
            o_expansion_active <= next_exp_active;
            o_expansion_pins <= next_exp_pins;
            o_drive_supply_on <= next_supply_on;
            o_controller_active <= controller_run;
            o_show_ram_data <= show_ram_data;
            o_clock_from_system <= frame_clock_select[3];
            o_frame_clock_div <= next_div;
            o_waveform_b <= waveform_type;
            o_regulator_run <= supply_source;
            o_pulse_num <= next_pnum;
            o_pulse_den <= next_pden;
        end
    end

    AST_SUPPLY_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!controller_run || i_standby) |=> !o_drive_supply_on)
        else $error("drive supply on while stopped or in standby");
    AST_SUPPLY_ON: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (drive_supply_switch && controller_run && !i_standby) |=> o_drive_supply_on)
        else $error("drive supply failed to turn on");
    AST_WR_READBACK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (wr_lane0 && hit_dc) |=> display_control == $past(i_wb_dat[7:0]))
        else $error("display control did not take written value");
    AST_ACK_ONE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held more than one cycle");
    AST_ALL_SEG: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!expansion_select && segment_pin_select[3] && controller_run) |=> o_seg_driver_en == 32'hffff_ffff)
        else $error("not all segment drivers enabled");
    AST_EXP_PORTS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (expansion_select && controller_run) |=> o_expansion_active && o_seg_driver_en == 32'h0000_0000)
        else $error("expansion mode pin assignment wrong");
    AST_HALT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !controller_run |=> (o_com_enable == 4'h0 && !o_expansion_active))
        else $error("controller outputs active while halted");
    AST_DIV_SYS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (frame_clock_select == 4'h8) |=> (o_frame_clock_div == 8'h02 && o_clock_from_system))
        else $error("system clock divide by two not selected");
    AST_PULSE_ZERO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (pulse_duty_select == 4'h7) |=> o_pulse_num == 6'h00)
        else $error("pulse duty code 0111 not zero");
    AST_PULSE_32: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (pulse_duty_select[3:2] == 2'b11) |=> (o_pulse_num == 6'h01 && o_pulse_den == LCC_PULSE_DEN_32))
        else $error("pulse duty codes 11xx not one in thirty-two");
    AST_RESET_VALUES: assert property (@(posedge i_clock)
        !i_rst_n |=> (port_duty_control == LCC_RST_PORT_DUTY && display_control == LCC_RST_DISPLAY &&
        waveform_supply_control == LCC_RST_WAVE_SUPPLY))
        else $error("control register not at its reset value");
    AST_ACK_AFTER_REQ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        bus_req |=> o_wb_ack)
        else $error("request not acknowledged in the next cycle");
    AST_RD_DISPLAY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (bus_req && !i_wb_we && hit_dc) |=> o_wb_dat == {24'h00_0000, $past(display_control)})
        else $error("display control read back wrong");
    AST_RD_UNMAPPED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (bus_req && !i_wb_we && !hit_pd && !hit_dc && !hit_ws) |=> o_wb_dat == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    AST_STATIC_ONE_COM: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (controller_run && duty_sel == 2'b00 && !common_doubling) |=> o_com_enable == 4'h1)
        else $error("static drive without doubling must use one common pin");
    AST_QUARTER_ALL_COM: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (controller_run && duty_sel == 2'b11) |=> (o_com_enable == 4'hf && o_com_source_4 == 4'h8))
        else $error("quarter duty must use all four common pins");
    AST_DOUBLING_ON: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (controller_run && common_doubling) |=> o_com_enable == 4'hf)
        else $error("doubling on but an unused common pin is idle");
    AST_DOUBLING_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (controller_run && !common_doubling && duty_sel == 2'b01) |=> (o_com_enable == 4'h3 &&
        o_com_source_3 == 4'h0 && o_com_source_4 == 4'h0))
        else $error("doubling off but an unused common pin repeats a waveform");
    AST_EXP_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !expansion_select |=> (!o_expansion_active && o_expansion_pins == 4'h0))
        else $error("expansion pins active with expansion off");
    AST_SEG_PORTS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!expansion_select && segment_pin_select[3:1] == 3'b000) |=> o_seg_driver_en == 32'h0000_0000)
        else $error("segment pins not all ports");
    AST_SEG_TOP8: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (controller_run && !expansion_select && segment_pin_select[3:1] == 3'b001) |=>
        o_seg_driver_en == 32'hff00_0000)
        else $error("top eight segment drivers not selected");
    AST_EXP_ORDER: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (expansion_select && controller_run) |=> (o_expansion_pins[3] == $past(i_latch_clock_out) &&
        o_expansion_pins[2] == $past(i_shift_clock_out) && o_expansion_pins[1] == $past(i_serial_segment_data) &&
        o_expansion_pins[0] == $past(i_alternation)))
        else $error("expansion pin order wrong");
    AST_BLANK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !show_ram_data |=> !o_show_ram_data)
        else $error("ram data shown while blank selected");
    AST_RAM_SHOWN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        show_ram_data |=> o_show_ram_data)
        else $error("blank shown while ram data selected");
    AST_WAVE_B: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        waveform_type |=> o_waveform_b)
        else $error("B waveform not selected");
    AST_WAVE_A: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !waveform_type |=> !o_waveform_b)
        else $error("A waveform not selected");
    AST_REGULATOR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        supply_source |=> o_regulator_run)
        else $error("regulator not running with regulated source selected");
    AST_MAIN_SUPPLY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !supply_source |=> !o_regulator_run)
        else $error("regulator running with main supply selected");
    AST_SUB_DIV4: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!frame_clock_select[3] && frame_clock_select[1]) |=> (o_frame_clock_div == 8'h04 && !o_clock_from_system))
        else $error("subclock divide by four not selected");
    AST_SYS_256: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (frame_clock_select == 4'hf) |=> (o_frame_clock_div == 8'h00 && o_clock_from_system))
        else $error("system clock divide by 256 not selected");
endmodule

// ==== lcc_expander_model.sv ====
`timescale 1ns/1ps
// stands in for the controller core feeding the expander pins; holds each pattern a full cycle
module lcc_expander_model (
    input wire logic i_clock,
    input wire logic [3:0] i_pattern,
    output logic o_latch_clock,
    output logic o_shift_clock,
    output logic o_serial_data,
    output logic o_alternation
);
    // software side never asks for expansion with a nonzero select
    always_ff @(posedge i_clock) begin
        {o_latch_clock, o_shift_clock, o_serial_data, o_alternation} <= i_pattern;
    end
endmodule

// ==== test_lcc_control_regs.sv ====
`timescale 1ns/1ps
module test_lcc_control_regs;
    import lcc_pkg::*;
    logic i_clock = 1'b0;
    logic rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, standby = 1'b0;
    logic [17:0] adr = 18'h0;
    logic [3:0] sel = 4'hf, pat = 4'h0, com_en, cs1, cs2, cs3, cs4, xp;
    wire [3:0] ex;
    logic [31:0] wdat = 32'h0, rdat, rd, seg;
    logic ack, x_act, sup_on, run, ram, sys, wave_b, reg_run;
    logic [1:0] duty;
    logic [7:0] div;
    logic [5:0] pnum, pden;
    int fails = 0, comparisons = 0, cycles = 0;

    lcc_expander_model lcc_expander_model_inst (.i_clock(i_clock), .i_pattern(pat), .o_latch_clock(ex[3]),
        .o_shift_clock(ex[2]), .o_serial_data(ex[1]), .o_alternation(ex[0]));
    lcc_control_regs lcc_control_regs_inst (.i_clock(i_clock), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_standby(standby), .i_latch_clock_out(ex[3]), .i_shift_clock_out(ex[2]),
        .i_serial_segment_data(ex[1]), .i_alternation(ex[0]), .o_duty(duty), .o_com_enable(com_en),
        .o_com_source_1(cs1), .o_com_source_2(cs2), .o_com_source_3(cs3), .o_com_source_4(cs4),
        .o_seg_driver_en(seg), .o_expansion_active(x_act), .o_expansion_pins(xp), .o_drive_supply_on(sup_on),
        .o_controller_active(run), .o_show_ram_data(ram), .o_clock_from_system(sys), .o_frame_clock_div(div),
        .o_waveform_b(wave_b), .o_regulator_run(reg_run), .o_pulse_num(pnum), .o_pulse_den(pden));

    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        // whole run needs well under 2000 cycles
        if (cycles == 5000) begin
            fails++;
            stop_test;
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle: hold request until ack is sampled, release at that edge
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge i_clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge i_clock);
        while (ack !== 1'b1) @(posedge i_clock);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    // longest path is model flop then output flop; read before the third edge's updates land
    task automatic settle;
        repeat (3) @(posedge i_clock);
    endtask

    initial begin
        logic [3:0] k;
        repeat (5) @(posedge i_clock);
        rst_n <= 1'b1;
        rdchk(LCC_IDX_PORT_DUTY, 8'h00);
        rdchk(LCC_IDX_DISPLAY, 8'h80);
        rdchk(LCC_IDX_WAVE_SUPPLY, 8'h60);
        rdchk(16'hffc3, 8'h00);
        wb(1'b1, LCC_IDX_PORT_DUTY, 8'hc8);
        wb(1'b1, LCC_IDX_DISPLAY, 8'hfe);
        wb(1'b1, LCC_IDX_WAVE_SUPPLY, 8'h70);
        settle;
        chk(duty, 2'b11);
        chk(com_en, 4'hf);
        chk(seg, 32'hffffffff);
        chk({sup_on, run, ram}, 3'b111);
        chk({sys, div}, {1'b1, 8'd128});
        chk({wave_b, reg_run}, 2'b01);
        chk({pnum, pden}, {6'd8, 6'd8});
        chk({cs1, cs2, cs3, cs4}, 16'h1248);
        rdchk(LCC_IDX_PORT_DUTY, 8'hc8);
        rdchk(LCC_IDX_DISPLAY, 8'hfe);
        standby <= 1'b1;
        settle;
        chk(sup_on, 1'b0);
        standby <= 1'b0;
        wb(1'b1, LCC_IDX_DISPLAY, 8'hae);
        settle;
        chk({sup_on, ram}, 2'b00);
        wb(1'b1, LCC_IDX_DISPLAY, 8'hde);
        settle;
        chk({sup_on, run, seg}, 34'h0);
        rdchk(LCC_IDX_PORT_DUTY, 8'hc8);
        sel <= 4'he;
        wb(1'b1, LCC_IDX_WAVE_SUPPLY, 8'hff);
        sel <= 4'hf;
        rdchk(LCC_IDX_WAVE_SUPPLY, 8'h70);
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            wb(1'b1, LCC_IDX_DISPLAY, {4'h7, k});
            wb(1'b1, LCC_IDX_WAVE_SUPPLY, {4'hf, k});
            wb(1'b1, LCC_IDX_PORT_DUTY, {k[1:0], 6'h09});
            settle;
            chk(sys, k[3]);
            chk(div, k[3] ? (k[2:0] == 3'h7 ? 8'h0 : 8'h2 << k[2:0])
                : (k[1] ? 8'h4 : k[0] ? 8'h2 : 8'h1));
            chk({pnum, pden}, k == 0 ? 12'o1010 : k < 7 ? {2'b0, k, 6'o10} : k == 7 ? 12'o0010
                : k[3:2] == 2'b10 ? 12'o0120 : 12'o0140);
            chk(duty, k[1:0]);
        end
        chk(wave_b, 1'b1);
        wb(1'b1, LCC_IDX_WAVE_SUPPLY, 8'h60);
        wb(1'b1, LCC_IDX_PORT_DUTY, 8'h28);
        settle;
        chk(reg_run, 1'b0);
        chk(cs2, 4'b0001);
        chk({com_en, cs1, cs3, cs4}, 16'hf111);
        wb(1'b1, LCC_IDX_PORT_DUTY, 8'h68);
        settle;
        chk({com_en, cs1, cs2, cs3, cs4}, 20'hf1212);
        wb(1'b1, LCC_IDX_PORT_DUTY, 8'h08);
        settle;
        chk({com_en, cs1, cs2, cs3, cs4}, 20'h11000);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, LCC_IDX_PORT_DUTY, {5'h0, 2'(i), 1'b1});
            settle;
            chk(seg, {32'h0, ~(32'hffffffff >> (8 * i))});
        end
        pat <= 4'ha;
        wb(1'b1, LCC_IDX_PORT_DUTY, 8'h10); // select stays 0000 alongside expansion
        settle;
        chk({x_act, seg, xp}, {1'b1, 32'h0, 4'ha});
        pat <= 4'h5;
        settle;
        chk(xp, 4'h5);
        wb(1'b1, LCC_IDX_PORT_DUTY, 8'h00);
        settle;
        chk({x_act, xp}, 5'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        rst_n <= 1'b1;
        rdchk(LCC_IDX_PORT_DUTY, 8'h00);
        rdchk(LCC_IDX_DISPLAY, 8'h80);
        rdchk(LCC_IDX_WAVE_SUPPLY, 8'h60);
        settle;
        chk({run, seg, pnum, pden, div}, {1'b0, 32'h0, 6'd8, 6'd8, 8'h01});
        stop_test;
    end
endmodule
